// ===== verilog/mie_core.sv
/*
 * Instruction execution core: fetch, decode and execute of arithmetic,
 * branch, bit, control and jump/call instructions, with return stack.
 * Assumes program and data memories answer combinationally in the cycle
 * the address is shown, and that all inputs except rst are synchronous to clock.
 */
// Functional notes
// (RL1) Add, and, compare, subtract use accumulator and memory or immediate.
// (RL2) Complement, rotate and shift act on the accumulator only.
// (RL3) A conditional branch jumps only when its condition holds.
// (RL4) Bit instructions reach any bit of any data space location.
// (RL5) Bit set and clear only force the bit; bit-test branches do testing.
// (RL6) Bit set and clear: two bytes, four cycles, 3-bit index, flags kept.
// (RL7) Short branches use a 5-bit signed displacement, -15 to +16.
// (RL8) Bit-test branches use an 8-bit signed displacement, -126 to +129.
// (RL9) Branch-if-bit-clear: 3 bytes, 5 cycles, jumps on 0, sets only carry.
// (RL10) Branch-if-bit-set: 3 bytes, 5 cycles, jumps on 1, sets only carry.
// (RL11) A bit-test branch copies the tested bit into carry, taken or not.
// (RL12) With the watchdog selected a stop instruction performs a wait.
// (RL13) Jump and call: 12-bit target, two bytes, four cycles, flags kept.
// (RL14) Short branches test carry or zero, take two cycles, keep flags.
// (RL15) Inc and dec set zero only; other ALU ops set both, in four cycles.
// (RL16) Return from interrupt restores flags; other control ops keep them.
`timescale 1ns/1ps
module mie_core
  import mie_pkg::*;
(
  input  wire logic            clock,       // core clock
  input  wire logic            rst,         // async reset, active high
  output logic      [PC_W-1:0] prog_addr,   // program byte address
  input  wire logic [7:0]      prog_rdata,  // program byte
  output logic      [7:0]      data_addr,   // data space address
  input  wire logic [7:0]      data_rdata,  // data space read byte
  output logic      [7:0]      data_wdata,  // data space write byte
  output logic                 data_we,     // data space write strobe
  input  wire logic            wdg_sel,     // watchdog function selected
  input  wire logic            irq_req,     // interrupt request level
  output logic                 irq_ack,     // interrupt entry pulse
  input  wire logic            wake,        // leave wait or stop
  output logic                 wait_mode,   // core in wait
  output logic                 stop_mode,   // core in stop
  output logic      [7:0]      accum,       // accumulator
  output logic                 flag_z,      // zero flag
  output logic                 flag_c,      // carry flag
  output logic      [PC_W-1:0] pc           // program counter
);

  mie_mode_e       mode_q, mode_d;
  logic [2:0]      cnt_q, cnt_d;
  logic [7:0]      op_q, op_d, b1_q, b1_d, b2_q, b2_d, mem_q, mem_d;
  logic [7:0]      acc_q, acc_d;
  logic            z_q, z_d, c_q, c_d, sz_q, sz_d, sc_q, sc_d;
  logic            inirq_q, inirq_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [2:0]      sp_q, sp_d;
  logic [PC_W-1:0] stk_q [STACK_DEPTH];
  logic [PC_W-1:0] stk_d [STACK_DEPTH];

  // Decode
  logic [3:0]      lo;
  logic [2:0]      cycles;
  logic [2:0]      bit_idx;
  logic [7:0]      bit_mask;
  logic            bit_val;
  logic            cond;
  mie_alu_e        alu_op;
  logic [7:0]      alu_opnd, alu_res;
  logic            alu_c, alu_z, alu_upd_c;
  logic [PC_W-1:0] rel5_tgt, rel8_tgt, ext_tgt;
  logic [2:0]      sp_inc, sp_dec;

  assign lo       = op_q[3:0];
  assign bit_idx  = op_q[7:OP_BIT_LSB];                             // RL6
  assign bit_mask = 8'h01 << bit_idx;                               // RL4
  assign bit_val  = mem_q[bit_idx];
  assign rel5_tgt = pc_q + LEN_1
                  + {{7{op_q[7]}}, op_q[7:OP_DISP_LSB]};            // RL7
  assign rel8_tgt = pc_q + LEN_2 + {{4{b2_q[7]}}, b2_q};            // RL8
  assign ext_tgt  = {op_q[7:4], b1_q};                              // RL13
  assign sp_inc   = (sp_q == 3'(STACK_DEPTH - 1)) ? 3'h0 : sp_q + 3'h1;
  assign sp_dec   = (sp_q == 3'h0) ? 3'(STACK_DEPTH - 1) : sp_q - 3'h1;

  always_comb
  begin
    unique case (op_q[2:1])                                         // RL14
      CND_ZERO_CLEAR:  cond = ~z_q;
      CND_CARRY_CLEAR: cond = ~c_q;
      CND_ZERO_SET:    cond = z_q;
      CND_CARRY_SET:   cond = c_q;
    endcase
  end

  always_comb
  begin
    if (op_q[0] == 1'b0)
      cycles = CYC_BRANCH;                                          // RL14
    else
      unique case (lo)
        LN_CALL, LN_JUMP:                 cycles = CYC_JUMP;        // RL13
        LN_BTEST:                         cycles = CYC_BTEST;       // RL9 RL10
        LN_BITOP:                         cycles = CYC_BITOP;       // RL6
        LN_ALU_MEM, LN_ALU_IMM, LN_ALU_ACC: cycles = CYC_ALU;       // RL15
        default:                          cycles = CYC_CTL;         // RL16
      endcase
  end

  always_comb
  begin
    if (op_q[7:4] <= 4'(ALU_DEC))
      alu_op = mie_alu_e'(op_q[7:4]);
    else
      alu_op = ALU_NONE;
    unique case (lo)
      LN_ALU_MEM: alu_opnd = mem_q;                                 // RL1
      LN_ALU_IMM: alu_opnd = b1_q;                                  // RL1
      default:    alu_opnd = acc_q;                                 // RL2
    endcase
  end

  mie_alu u_alu (
    .op    (alu_op),
    .acc   (acc_q),
    .opnd  (alu_opnd),
    .c_in  (c_q),
    .res   (alu_res),
    .c_out (alu_c),
    .z_out (alu_z),
    .upd_c (alu_upd_c)
  );

  always_comb
  begin
    mode_d     = mode_q;
    cnt_d      = cnt_q;
    op_d       = op_q;
    b1_d       = b1_q;
    b2_d       = b2_q;
    mem_d      = mem_q;
    acc_d      = acc_q;
    z_d        = z_q;
    c_d        = c_q;
    sz_d       = sz_q;
    sc_d       = sc_q;
    inirq_d    = inirq_q;
    pc_d       = pc_q;
    sp_d       = sp_q;
    stk_d      = stk_q;
    data_we    = 1'b0;
    data_wdata = mem_q;
    irq_ack    = 1'b0;
    unique case (mode_q)
      MODE_RUN:
      begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h0 && irq_req && !inirq_q)
        begin
          // Interrupt entry at instruction boundary
          stk_d[sp_q] = pc_q;
          sp_d        = sp_inc;
          sz_d        = z_q;
          sc_d        = c_q;
          inirq_d     = 1'b1;
          pc_d        = IRQ_ENTRY;
          irq_ack     = 1'b1;
          cnt_d       = 3'h0;
        end
        else if (cnt_q == 3'h0)
          op_d = prog_rdata;
        else
        begin
          if (cnt_q == 3'h1)
            b1_d = prog_rdata;
          if (cnt_q == 3'h2)
          begin
            b2_d  = prog_rdata;
            mem_d = data_rdata;
          end
          if (cnt_q == cycles - 3'h1)
          begin
            cnt_d = 3'h0;
            if (op_q[0] == 1'b0)
              pc_d = cond ? rel5_tgt : pc_q + LEN_1;                // RL3
            else
              unique case (lo)
                LN_CALL, LN_JUMP:
                begin
                  if (lo == LN_CALL)
                  begin
                    stk_d[sp_q] = pc_q + LEN_2;
                    sp_d        = sp_inc;
                  end
                  pc_d = ext_tgt;                                   // RL13
                end
                LN_BTEST:
                begin
                  c_d  = bit_val;                                   // RL11
                  pc_d = (bit_val == op_q[OP_SEL_POS])              // RL9 RL10
                       ? rel8_tgt : pc_q + LEN_3;
                end
                LN_BITOP:
                begin
                  data_we    = 1'b1;                                // RL5
                  data_wdata = op_q[OP_SEL_POS] ? (mem_q | bit_mask)
                                                : (mem_q & ~bit_mask); // RL6
                  pc_d       = pc_q + LEN_2;
                end
                LN_ALU_MEM, LN_ALU_IMM, LN_ALU_ACC:
                begin
                  if (alu_op != ALU_NONE)
                    z_d = alu_z;                                    // RL15
                  if (alu_upd_c)
                    c_d = alu_c;                                    // RL15
                  if ((alu_op == ALU_INC || alu_op == ALU_DEC)
                      && lo == LN_ALU_MEM)
                  begin
                    data_we    = 1'b1;
                    data_wdata = alu_res;
                  end
                  else if (alu_op != ALU_CP && alu_op != ALU_NONE)
                    acc_d = alu_res;                                // RL1 RL2
                  pc_d = pc_q + ((lo == LN_ALU_ACC) ? LEN_1 : LEN_2);
                end
                default:
                begin
                  pc_d = pc_q + LEN_1;
                  unique case (op_q[7:4])
                    CTL_RET, CTL_RETURN_FROM_INTERRUPT:
                    begin
                      pc_d = stk_q[sp_dec];
                      sp_d = sp_dec;
                      if (op_q[7:4] == CTL_RETURN_FROM_INTERRUPT)
                      begin
                        z_d     = sz_q;                             // RL16
                        c_d     = sc_q;                             // RL16
                        inirq_d = 1'b0;
                      end
                    end
                    CTL_STOP:
                      mode_d = wdg_sel ? MODE_WAIT : MODE_STOP;     // RL12
                    CTL_WAIT:
                      mode_d = MODE_WAIT;
                    default:
                      pc_d = pc_q + LEN_1;
                  endcase
                end
              endcase
          end
        end
      end
      MODE_WAIT, MODE_STOP:
        if (wake || irq_req)
          mode_d = MODE_RUN;
      default:
        mode_d = MODE_RUN;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mode_q  <= MODE_RUN;
      cnt_q   <= 3'h0;
      op_q    <= 8'h00;
      b1_q    <= 8'h00;
      b2_q    <= 8'h00;
      mem_q   <= 8'h00;
      acc_q   <= 8'h00;
      z_q     <= 1'b0;
      c_q     <= 1'b0;
      sz_q    <= 1'b0;
      sc_q    <= 1'b0;
      inirq_q <= 1'b0;
      pc_q    <= PC_RESET;
      sp_q    <= 3'h0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stk_q[i] <= PC_RESET;
    end
    else
    begin
      mode_q  <= mode_d;
      cnt_q   <= cnt_d;
      op_q    <= op_d;
      b1_q    <= b1_d;
      b2_q    <= b2_d;
      mem_q   <= mem_d;
      acc_q   <= acc_d;
      z_q     <= z_d;
      c_q     <= c_d;
      sz_q    <= sz_d;
      sc_q    <= sc_d;
      inirq_q <= inirq_d;
      pc_q    <= pc_d;
      sp_q    <= sp_d;
      stk_q   <= stk_d;
    end
  end

  // Operand bytes follow the opcode; data space address is the second byte
  assign prog_addr = pc_q + {9'h000, cnt_q};
  assign data_addr = b1_q;
  assign wait_mode = (mode_q == MODE_WAIT);
  assign stop_mode = (mode_q == MODE_STOP);
  assign accum     = acc_q;
  assign flag_z    = z_q;
  assign flag_c    = c_q;
  assign pc        = pc_q;

endmodule // mie_core

// ===== verilog/mie_pkg.sv
/*
 * Shared constants of the instruction execution core: opcode layout,
 * operation codes, cycle and byte counts, reset values.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package mie_pkg;

  localparam int PC_W       = 12;
  localparam int STACK_DEPTH = 6;

  // Low nibble of the opcode selects the instruction class
  localparam logic [3:0] LN_CALL    = 4'h1;
  localparam logic [3:0] LN_JUMP    = 4'h9;
  localparam logic [3:0] LN_BTEST   = 4'h3;
  localparam logic [3:0] LN_BITOP   = 4'hB;
  localparam logic [3:0] LN_ALU_MEM = 4'h5;
  localparam logic [3:0] LN_ALU_IMM = 4'h7;
  localparam logic [3:0] LN_CTL     = 4'hD;
  localparam logic [3:0] LN_ALU_ACC = 4'hF;

  // Short branch condition in opcode bits 2:1
  localparam logic [1:0] CND_ZERO_CLEAR  = 2'h0;
  localparam logic [1:0] CND_CARRY_CLEAR = 2'h1;
  localparam logic [1:0] CND_ZERO_SET    = 2'h2;
  localparam logic [1:0] CND_CARRY_SET   = 2'h3;

  // Field positions
  localparam int OP_BIT_LSB  = 5;
  localparam int OP_SEL_POS  = 4;
  localparam int OP_DISP_LSB = 3;

  // Control codes in opcode bits 7:4
  localparam logic [3:0] CTL_NOP      = 4'h0;
  localparam logic [3:0] CTL_RET      = 4'h1;
  localparam logic [3:0] CTL_RETURN_FROM_INTERRUPT     = 4'h2;
  localparam logic [3:0] CTL_STOP     = 4'h3;
  localparam logic [3:0] CTL_WAIT     = 4'h4;

  // Cycle counts per class
  localparam logic [2:0] CYC_BRANCH = 3'h2;
  localparam logic [2:0] CYC_CTL    = 3'h2;
  localparam logic [2:0] CYC_ALU    = 3'h4;
  localparam logic [2:0] CYC_BITOP  = 3'h4;
  localparam logic [2:0] CYC_JUMP   = 3'h4;
  localparam logic [2:0] CYC_BTEST  = 3'h5;

  // Byte counts
  localparam logic [PC_W-1:0] LEN_1 = 12'h001;
  localparam logic [PC_W-1:0] LEN_2 = 12'h002;
  localparam logic [PC_W-1:0] LEN_3 = 12'h003;

  localparam logic [PC_W-1:0] PC_RESET  = 12'h000;
  localparam logic [PC_W-1:0] IRQ_ENTRY = 12'h004;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_AND, ALU_CP, ALU_SUB, ALU_COM,
    ALU_RLC, ALU_SLA, ALU_INC, ALU_DEC, ALU_NONE
  } mie_alu_e;

  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP} mie_mode_e;

endpackage

// ===== verilog/mie_alu.sv
/*
 * Accumulator arithmetic and logic unit, purely combinational.
 * Assumes the caller chooses the operand and where the result goes.
 */
`timescale 1ns/1ps
module mie_alu
  import mie_pkg::*;
(
  input  wire mie_alu_e   op,      // operation
  input  wire logic [7:0] acc,     // accumulator value
  input  wire logic [7:0] opnd,    // second operand
  input  wire logic       c_in,    // carry before
  output logic      [7:0] res,     // result
  output logic            c_out,   // carry after
  output logic            z_out,   // zero after
  output logic            upd_c    // operation alters carry
);

  logic [8:0] wide;

  always_comb
  begin
    wide  = 9'h000;
    upd_c = 1'b1;
    c_out = c_in;
    unique case (op)
      ALU_ADD: wide = {1'b0, acc} + {1'b0, opnd};
      ALU_SUB, ALU_CP: wide = {1'b0, acc} - {1'b0, opnd};
      ALU_AND: wide = {1'b0, acc & opnd};
      ALU_COM: wide = {acc[7], ~acc};
      ALU_RLC: wide = {acc, c_in};
      ALU_SLA: wide = {acc, 1'b0};
      ALU_INC:
      begin
        wide  = {1'b0, opnd + 8'h01};
        upd_c = 1'b0;  // RL15
      end
      ALU_DEC:
      begin
        wide  = {1'b0, opnd - 8'h01};
        upd_c = 1'b0;  // RL15
      end
      default:
      begin
        wide  = {1'b0, acc};
        upd_c = 1'b0;
      end
    endcase
    res = wide[7:0];
    if (upd_c)
      c_out = wide[8];
    z_out = (wide[7:0] == 8'h00);
  end

endmodule // mie_alu

// ===== bench/mie_core_monitor.sv
/*
 * Port checker of the execution core: instruction lengths, branch
 * targets, bit writes, flag keeping and stop/wait selection.
 * Assumes every fetch at pc that does not enter an interrupt starts an
 * instruction.
 */
`timescale 1ns/1ps
module mie_core_monitor
  import mie_pkg::*;
(
  input wire logic            clock,      // core clock
  input wire logic            rst,        // async reset
  input wire logic [PC_W-1:0] prog_addr,  // program address
  input wire logic [7:0]      prog_rdata, // program byte
  input wire logic [7:0]      data_addr,  // data address
  input wire logic [7:0]      data_rdata, // data byte read
  input wire logic [7:0]      data_wdata, // data byte written
  input wire logic            data_we,    // write strobe
  input wire logic            irq_ack,    // interrupt entry
  input wire logic            wdg_sel,    // watchdog selected
  input wire logic            wait_mode,  // in wait
  input wire logic            stop_mode,  // in stop
  input wire logic            flag_z,     // zero flag
  input wire logic            flag_c,     // carry flag
  input wire logic [PC_W-1:0] pc          // program counter
);
  logic            c0;
  logic            br_ok;
  logic            bt_bit;
  logic [PC_W-1:0] br_nx;
  logic [PC_W-1:0] bt_nx;
  logic [7:0]      qmask;
  logic [1:0]      zc;
  logic [7:0]      op_d;
  logic [7:0]      op_q;

  // First cycle of an instruction
  assign c0 = !wait_mode && !stop_mode && !irq_ack && prog_addr == pc;
  assign zc = {flag_z, flag_c};
  assign br_nx = br_ok ? pc + LEN_1 + {{7{prog_rdata[7]}}, prog_rdata[7:3]}
                       : pc + LEN_1;
  // Valid in the third cycle of a bit-test branch
  assign bt_bit = data_rdata[op_q[7:5]];
  assign bt_nx = (bt_bit == op_q[4]) ?
                 pc + LEN_2 + {{4{prog_rdata[7]}}, prog_rdata} : pc + LEN_3;
  assign qmask = 8'h01 << op_q[7:5];
  always_comb
    case (prog_rdata[2:1])
      CND_ZERO_CLEAR:  br_ok = !flag_z;
      CND_CARRY_CLEAR: br_ok = !flag_c;
      CND_ZERO_SET:    br_ok = flag_z;
      default:         br_ok = flag_c;
    endcase
  always_comb
    op_d = c0 ? prog_rdata : op_q;
  always_ff @(posedge clock or posedge rst)
    if (rst)
      op_q <= 8'h00;
    else
      op_q <= op_d;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_short_branch: assert property (
    c0 && !prog_rdata[0] |-> ##2
    pc == $past(br_nx, 2) && zc == $past(zc, 2))
    else $error("short branch target or flags wrong");
  chk_bit_write: assert property (
    c0 && prog_rdata[3:0] == LN_BITOP |-> ##3 data_we &&
    data_addr == $past(prog_rdata, 2) && data_wdata == (op_q[4] ?
    $past(data_rdata) | qmask : $past(data_rdata) & ~qmask))
    else $error("bit set or clear wrote a wrong byte");
  chk_bit_len: assert property (
    c0 && prog_rdata[3:0] == LN_BITOP |-> ##4
    pc == $past(pc, 4) + LEN_2 && zc == $past(zc, 4))
    else $error("bit set or clear length or flags wrong");
  chk_btest_branch: assert property (
    c0 && prog_rdata[3:0] == LN_BTEST |-> ##5 pc == $past(bt_nx, 3) &&
    flag_c == $past(bt_bit, 3) && flag_z == $past(flag_z, 5))
    else $error("bit-test branch target or flags wrong");
  chk_jump_target: assert property (
    c0 && prog_rdata[3:0] == LN_JUMP |-> ##4
    pc == {op_q[7:4], $past(prog_rdata, 3)} && zc == $past(zc, 4))
    else $error("jump target or flags wrong");
  chk_alu_len: assert property (
    c0 && prog_rdata[3:0] == LN_ALU_IMM |-> ##1 !data_we [*3] ##1
    pc == $past(pc, 4) + LEN_2)
    else $error("immediate operation length wrong");
  chk_nop_keep: assert property (
    c0 && prog_rdata == {CTL_NOP, LN_CTL} |-> ##2
    pc == $past(pc, 2) + LEN_1 && zc == $past(zc, 2))
    else $error("no-op length or flags wrong");
  chk_stop_wdg: assert property (
    stop_mode |-> !wdg_sel)
    else $error("stop entered with watchdog selected");
  chk_we_pulse: assert property (
    data_we |=> !data_we)
    else $error("write strobe longer than one cycle");

  cover property (wait_mode);
  cover property (stop_mode);
  cover property (c0 && prog_rdata[3:0] == LN_BTEST);
  cover property (irq_ack);
endmodule // mie_core_monitor

// ===== bench/mie_core_test.sv
/*
 * Self-checking bench of the execution core: small random programs
 * run to a jump-to-self, then end state compared with expectations.
 * Assumes memories here answer within the cycle the address is shown.
 */
`timescale 1ns/1ps
module mie_core_test
  import mie_pkg::*;
;
  logic            clock, rst, wdg_sel, irq_req, wake, data_we, irq_ack;
  logic            wait_mode, stop_mode, flag_z, flag_c, s, tk, w;
  logic [PC_W-1:0] prog_addr, pc, tg;
  logic [7:0]      prog_rdata, data_addr, data_rdata, data_wdata, accum;
  logic [7:0]      a, b, m, n, o, kk, x, y, d, g, e;
  logic [2:0]      k, j;
  logic [4:0]      d5;
  logic [1:0]      cnd, f2;
  logic [7:0]      rom [4096];
  logic [7:0]      ram [256];
  int              fails, n_checks, t, r;

  mie_core DUT (.clock, .rst, .prog_addr, .prog_rdata, .data_addr,
    .data_rdata, .data_wdata, .data_we, .wdg_sel, .irq_req, .irq_ack,
    .wake, .wait_mode, .stop_mode, .accum, .flag_z, .flag_c, .pc);

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(negedge clock)
  begin
    prog_rdata <= rom[prog_addr];
    data_rdata <= ram[data_addr];
  end
  always @(posedge clock)
    if (data_we === 1'b1)
      ram[data_addr] <= data_wdata;

  task automatic chk(input string nm, input logic [11:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [1:0] fl(input logic [7:0] p, q);
    logic [8:0] sum;
    sum = {1'b0, p} + {1'b0, q};
    return {sum[7:0] == 8'h00, sum[8]};
  endfunction
  // Holds reset while the program is replaced
  task load(input logic [95:0] v);
    int i;
    rst = 1'b1;
    foreach (rom[q]) rom[q] = 8'hFF;
    for (i = 0; i < 12; i++) rom[i] = v[95-8*i -: 8];
  endtask
  task halt(input logic [11:0] ad);
    rom[ad] = {ad[11:8], LN_JUMP};
    rom[ad + 12'h001] = ad[7:0];
  endtask
  task wait_pc(input logic [11:0] ep);
    int i;
    for (i = 0; i < 500 && pc !== ep; i++) @(negedge clock);
    if (pc !== ep)
    begin
      chk("pc timeout", pc, ep);
      tally_and_finish;
    end
  endtask
  task go(input logic [11:0] ep);
    repeat (12) @(negedge clock);
    rst = 1'b0;
    wait_pc(ep);
  endtask

  initial
  begin
    rst = 1'b1;
    wdg_sel = 1'b0;
    irq_req = 1'b0;
    wake = 1'b0;
    fails = 0;
    n_checks = 0;
    r = $urandom(9);
    foreach (ram[q]) ram[q] = $urandom;
    for (t = 0; t < 4; t++)
    begin
      a = $urandom;
      b = $urandom;
      m = $urandom;
      d = a - b;
      e = ~d;
      g = {e[5:0], d[7], 1'b0};
      kk = t[0] ? g : $urandom;
      load({8'h07, a, 8'h35, m, 24'h4F5F6F, 8'h27, kk, 8'h75, m ^ 8'h01,
            8'hFF});
      halt(12'h00B);
      ram[m] = b;
      ram[m ^ 8'h01] = (t == 2) ? 8'hFF : $urandom;
      n = ram[m ^ 8'h01];
      go(12'h00B);
      chk("accum", accum, g);
      chk("carry", flag_c, g < kk);
      chk("zero", flag_z, n + 8'h01 == 8'h00);
      chk("inc mem", ram[m ^ 8'h01], 8'(n + 8'h01));
    end
    for (t = 0; t < 4; t++)
    begin
      x = $urandom;
      y = $urandom;
      m = $urandom;
      k = $urandom;
      j = $urandom;
      load({8'h07, x, 8'h07, y, k, 1'b1, 4'hB, m, j, 1'b0, 4'hB,
            m ^ 8'h01, 32'hFFFFFFFF});
      halt(12'h008);
      n = ram[m];
      o = ram[m ^ 8'h01];
      go(12'h008);
      chk("bit set", ram[m], n | (8'h01 << k));
      chk("bit clear", ram[m ^ 8'h01], o & ~(8'h01 << j));
      chk("flags", {flag_z, flag_c}, fl(x, y));
    end
    for (t = 0; t < 6; t++)
    begin
      x = $urandom;
      y = $urandom;
      m = $urandom;
      k = $urandom;
      s = t[0];
      d = (t < 2) ? 8'h7F : (t < 4) ? 8'h80 : 8'h10 | 7'($urandom);
      tg = 12'h006 + {{4{d[7]}}, d};
      n = ram[m];
      tk = (n[k] == s);
      f2 = fl(x, y);
      load({8'h07, x, 8'h07, y, k, s, 4'h3, m, d, 40'hFFFFFFFFFF});
      halt(12'h007);
      halt(tg);
      go(tk ? tg : 12'h007);
      chk("flags", {flag_z, flag_c}, {f2[1], n[k]});
    end
    for (t = 0; t < 16; t++)
    begin
      cnd = t[3:2];
      x = (t[1:0] < 2) ? 8'hFF : {7'h00, t[0]};
      y = (t[1:0] == 2) ? 8'h00 : {6'h00, t[0] ^ t[1], ~t[0]};
      f2 = fl(x, y);
      d5 = (t[3] ^ t[0]) ? 5'h10 : 5'h0F;
      tg = 12'h005 + {{7{d5[4]}}, d5};
      case (cnd)
        CND_ZERO_CLEAR:  tk = !f2[1];
        CND_CARRY_CLEAR: tk = !f2[0];
        CND_ZERO_SET:    tk = f2[1];
        default:         tk = f2[0];
      endcase
      load({8'h07, x, 8'h07, y, d5, cnd, 1'b0, 56'hFFFFFFFFFFFFFF});
      halt(12'h005);
      halt(tg);
      go(tk ? tg : 12'h005);
      chk("flags", {flag_z, flag_c}, f2);
    end
    x = $urandom;
    y = $urandom;
    load({8'h07, x, 8'h07, y, 8'hA1, 8'hBC, 48'hFFFFFFFFFFFF});
    rom[12'hABC] = 8'h1D;
    halt(12'h006);
    go(12'h006);
    chk("flags", {flag_z, flag_c}, fl(x, y));
    for (t = 0; t < 2; t++)
    begin
      w = t[0];
      x = $urandom;
      y = $urandom;
      load({8'h07, x, 8'h07, y, 8'h3D, 8'h0D, 48'hFFFFFFFFFFFF});
      halt(12'h006);
      wdg_sel = w;
      go(12'h005);
      repeat (3) @(negedge clock);
      chk("modes", {wait_mode, stop_mode}, w ? 2'b10 : 2'b01);
      chk("pc held", pc, 12'h005);
      wake = 1'b1;
      @(negedge clock);
      wake = 1'b0;
      wait_pc(12'h006);
      chk("flags", {flag_z, flag_c}, fl(x, y));
    end
    // And, decrement, wait, then interrupt whose handler compares and returns
    for (t = 0; t < 2; t++)
    begin
      x = t[0] ? 8'($urandom) : 8'h01;
      y = t[0] ? 8'($urandom) : 8'h01;
      e = (x & y) - 8'h01;
      load({8'h09, 8'h08, 16'hFFFF, 8'h27, 8'hFF, 8'h2D, 8'hFF, 8'h07, x,
            8'h17, y});
      rom[12'h00C] = 8'h8F;
      rom[12'h00D] = 8'h4D;
      halt(12'h00E);
      go(12'h00E);
      repeat (2) @(negedge clock);
      chk("wait", {wait_mode, stop_mode}, 2'b10);
      irq_req = 1'b1;
      for (r = 0; r < 8 && irq_ack !== 1'b1; r++) @(negedge clock);
      chk("irq ack", irq_ack, 1'b1);
      @(negedge clock);
      irq_req = 1'b0;
      chk("irq entry", pc, IRQ_ENTRY);
      wait_pc(12'h006);
      wait_pc(12'h00E);
      chk("accum", accum, e);
      chk("flags", {flag_z, flag_c}, {e == 8'h00, 1'b0});
    end
    tally_and_finish;
  end
endmodule // mie_core_test

bind mie_core mie_core_monitor MON (.clock, .rst, .prog_addr, .prog_rdata,
  .data_addr, .data_rdata, .data_wdata, .data_we, .wdg_sel, .wait_mode,
  .irq_ack, .stop_mode, .flag_z, .flag_c, .pc);
